/* File: rtl/crc_fifo_timer_status_consts.vh */
`ifndef CRC_FIFO_TIMER_STATUS_CONSTS_VH
`define CRC_FIFO_TIMER_STATUS_CONSTS_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define IDX_CRC_FIFO_TIMER_STATUS  6'h07
`define IDX_FIFO_THRESHOLD         6'h10
`define IDX_NEAR_EMPTY_LATCH       6'h11
`define IDX_EVENT_STATUS           6'h12
`define IDX_EVENT_MASK             6'h13

// ************************************************************
// Reset values
// ************************************************************
`define RST_CRC_FIFO_TIMER_STATUS  8'h21
`define RST_FIFO_THRESHOLD         6'h08
`define RST_EVENT_MASK             4'h0
`define RST_EVENT_LEVELS           4'h5

// ************************************************************
// Status register bit positions
// ************************************************************
`define BIT_CRC_RESULT_ZERO        6
`define BIT_CRC_DONE               5
`define BIT_ATTENTION              4
`define BIT_TIMER_ACTIVE           3
`define BIT_FIFO_NEAR_FULL         1
`define BIT_FIFO_NEAR_EMPTY        0

// ************************************************************
// Latch register bit positions
// ************************************************************
`define BIT_LATCH_SET_SELECT       7
`define BIT_LATCH_NEAR_EMPTY       2

// ************************************************************
// Event bit positions
// ************************************************************
`define EVT_CRC_DONE               0
`define EVT_FIFO_NEAR_FULL         1
`define EVT_FIFO_NEAR_EMPTY        2
`define EVT_ATTENTION              3

// ************************************************************
// FIFO geometry
// ************************************************************
`define FIFO_DEPTH                 8'h40

`endif

/* File: rtl/crc_fifo_timer_status_register.v */
// Contract
// - The status register sits at index 07h and resets to 21h.
// - Bit 6 is high when the CRC engine result equals zero.
// - The result-zero flag is held low while a CRC calculation is busy.
// - Bit 5 is set once the CRC calculation has finished.
// - Bit 4 is high while any pending request has its enable bit set.
// - Bit 3 is high while the timer unit is running.
// - In gated timer mode bit 3 follows the timer enable, not the gate level.
// - Bit 1 is high when 64 minus the fill count is at or below the threshold.
// - Bit 0 is high when the fill count is at or below the threshold.
// - Bits 7 and 2 read zero and host writes never change the status register.
// - A rise of near-empty sets a latched request cleared only through the set/clear select write.
`timescale 1ns/1ns
`include "crc_fifo_timer_status_consts.vh"

module crc_fifo_timer_status_register #(
    parameter IRQ_SRC_WIDTH = 11
) (
    // Clock and reset
    input  wire                     core_clk,
    input  wire                     reset_n,
    // Wishbone slave
    input  wire                     wbCyc,
    input  wire                     wbStb,
    input  wire                     wbWe,
    input  wire [7:0]               wbAdr,
    input  wire [3:0]               wbSel,
    input  wire [31:0]              wbDatIn,
    output reg  [31:0]              wbDatOut,
    output reg                      wbAck,
    // CRC engine state
    input  wire                     crcBusy,
    input  wire                     crcResultZero,
    input  wire                     crcDone,
    // Timer state
    input  wire                     timerRunning,
    input  wire                     timerEnabled,
    input  wire                     timerGatedMode,
    // FIFO state
    input  wire [6:0]               fifoFillCount,
    // Interrupt requests and enables
    input  wire [IRQ_SRC_WIDTH-1:0] irqPending,
    input  wire [IRQ_SRC_WIDTH-1:0] irqEnable,
    // Results
    output reg  [7:0]               statusFlags,
    output reg                      fifoNearEmptyLatch,
    output reg                      irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam EVT_WIDTH = 4;

    reg  [7:0]           crcFifoTimerStatus_reg;
    reg  [7:0]           crcFifoTimerStatus_next;
    reg  [5:0]           fifoThreshold_reg;
    reg  [5:0]           fifoThreshold_next;
    reg                  nearEmptyLatch_reg;
    reg                  nearEmptyLatch_next;
    reg  [EVT_WIDTH-1:0] eventMask_reg;
    reg  [EVT_WIDTH-1:0] eventMask_next;
    reg  [31:0]          readData;
    reg                  liveResultZero;
    reg                  liveTimerActive;
    reg                  liveNearFull;
    reg                  liveNearEmpty;
    reg                  liveAttention;
    reg  [7:0]           fillCountWide;
    reg  [7:0]           freeSpace;
    reg  [7:0]           thresholdWide;
    wire                 busRequest;
    wire                 busWrite;
    wire                 busRead;
    wire [5:0]           wordIndex;
    wire                 lowLaneWrite;
    wire                 eventStatusRead;
    wire [EVT_WIDTH-1:0] eventLevels;
    wire [EVT_WIDTH-1:0] eventPulses;
    wire [EVT_WIDTH-1:0] eventStatus;
    wire                 eventIrq;
    wire                 nearEmptyRise;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function mapped;
        input [5:0] idx;
        begin
            mapped = (idx == `IDX_CRC_FIFO_TIMER_STATUS) ||
                     (idx == `IDX_FIFO_THRESHOLD) ||
                     (idx == `IDX_NEAR_EMPTY_LATCH) ||
                     (idx == `IDX_EVENT_STATUS) ||
                     (idx == `IDX_EVENT_MASK);
        end
    endfunction

    function hits;
        input [5:0] idx;
        input [5:0] target;
        begin
            hits = (idx == target);
        end
    endfunction

    // ************************************************************
    // Bus request decode
    // ************************************************************
    assign busRequest   = wbCyc & wbStb & ~wbAck;
    assign busWrite     = busRequest & wbWe;
    assign busRead      = busRequest & ~wbWe;
    assign wordIndex    = wbAdr[7:2];
    assign lowLaneWrite = busWrite & wbSel[0];

    assign eventStatusRead = busRead & hits(wordIndex, `IDX_EVENT_STATUS);

    // ************************************************************
    // Live flag evaluation
    // ************************************************************
    always @* begin
        fillCountWide = {1'b0, fifoFillCount};
        thresholdWide = {2'b00, fifoThreshold_reg};
        freeSpace     = `FIFO_DEPTH - fillCountWide;

        liveResultZero = crcResultZero & ~crcBusy;

        if (timerGatedMode) begin
            liveTimerActive = timerEnabled;
        end else begin
            liveTimerActive = timerRunning;
        end

        liveNearFull = (freeSpace <= thresholdWide);

        liveNearEmpty = (fillCountWide <= thresholdWide);

        liveAttention = |(irqPending & irqEnable);
    end

    // ************************************************************
    // Status register image
    // ************************************************************
    always @* begin
        crcFifoTimerStatus_next = 8'h00;
        crcFifoTimerStatus_next[`BIT_CRC_RESULT_ZERO] = liveResultZero;
        crcFifoTimerStatus_next[`BIT_CRC_DONE]        = crcDone & ~crcBusy;
        crcFifoTimerStatus_next[`BIT_ATTENTION]       = liveAttention;
        crcFifoTimerStatus_next[`BIT_TIMER_ACTIVE]    = liveTimerActive;
        crcFifoTimerStatus_next[`BIT_FIFO_NEAR_FULL]  = liveNearFull;
        crcFifoTimerStatus_next[`BIT_FIFO_NEAR_EMPTY] = liveNearEmpty;
    end

    // ************************************************************
    // Writable register next values
    // ************************************************************
    always @* begin
        fifoThreshold_next = fifoThreshold_reg;
        eventMask_next     = eventMask_reg;
        if (lowLaneWrite && hits(wordIndex, `IDX_FIFO_THRESHOLD)) begin
            fifoThreshold_next = wbDatIn[5:0];
        end
        if (lowLaneWrite && hits(wordIndex, `IDX_EVENT_MASK)) begin
            eventMask_next = wbDatIn[EVT_WIDTH-1:0];
        end
    end

    // ************************************************************
    // Latched near-empty request
    // ************************************************************
    always @* begin
        nearEmptyLatch_next = nearEmptyLatch_reg;
        if (lowLaneWrite && hits(wordIndex, `IDX_NEAR_EMPTY_LATCH) && wbDatIn[`BIT_LATCH_NEAR_EMPTY]) begin
            nearEmptyLatch_next = wbDatIn[`BIT_LATCH_SET_SELECT];
        end
        if (nearEmptyRise) begin
            nearEmptyLatch_next = 1'b1;
        end
    end

    // ************************************************************
    // Register read mux
    // ************************************************************
    always @* begin
        readData = 32'h00000000;
        case (wordIndex)
            `IDX_CRC_FIFO_TIMER_STATUS: begin
                readData[7:0] = crcFifoTimerStatus_reg;
            end
            `IDX_FIFO_THRESHOLD: begin
                readData[5:0] = fifoThreshold_reg;
            end
            `IDX_NEAR_EMPTY_LATCH: begin
                readData[`BIT_LATCH_NEAR_EMPTY] = nearEmptyLatch_reg;
            end
            `IDX_EVENT_STATUS: begin
                readData[EVT_WIDTH-1:0] = eventStatus;
            end
            `IDX_EVENT_MASK: begin
                readData[EVT_WIDTH-1:0] = eventMask_reg;
            end
            default: begin
                readData = 32'h00000000;
            end
        endcase
    end

    // ************************************************************
    // Clocked state
    // ************************************************************
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            crcFifoTimerStatus_reg <= `RST_CRC_FIFO_TIMER_STATUS;
            fifoThreshold_reg      <= `RST_FIFO_THRESHOLD;
            nearEmptyLatch_reg     <= 1'b0;
            eventMask_reg          <= `RST_EVENT_MASK;
        end else begin
            crcFifoTimerStatus_reg <= crcFifoTimerStatus_next;
            fifoThreshold_reg      <= fifoThreshold_next;
            nearEmptyLatch_reg     <= nearEmptyLatch_next;
            eventMask_reg          <= eventMask_next;
        end
    end

    // ************************************************************
    // Wishbone answer
    // ************************************************************
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wbAck    <= 1'b0;
            wbDatOut <= 32'h00000000;
        end else begin
            wbAck <= busRequest;
            if (busRead && mapped(wordIndex)) begin
                wbDatOut <= readData;
            end else begin
                wbDatOut <= 32'h00000000;
            end
        end
    end

    // ************************************************************
    // Output copies
    // ************************************************************
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            statusFlags        <= `RST_CRC_FIFO_TIMER_STATUS;
            fifoNearEmptyLatch <= 1'b0;
            irq                <= 1'b0;
        end else begin
            statusFlags        <= crcFifoTimerStatus_next;
            fifoNearEmptyLatch <= nearEmptyLatch_next;
            irq                <= eventIrq;
        end
    end

    // ************************************************************
    // Event sources
    // ************************************************************
    assign eventLevels[`EVT_CRC_DONE]        = crcFifoTimerStatus_next[`BIT_CRC_DONE];
    assign eventLevels[`EVT_FIFO_NEAR_FULL]  = liveNearFull;
    assign eventLevels[`EVT_FIFO_NEAR_EMPTY] = liveNearEmpty;
    assign eventLevels[`EVT_ATTENTION]       = liveAttention;

    assign nearEmptyRise = eventPulses[`EVT_FIFO_NEAR_EMPTY];

    // Detector idles at the reset image levels, no false edge after reset
    rise_detect #(
        .WIDTH       (EVT_WIDTH),
        .RESET_LEVEL (`RST_EVENT_LEVELS)
    ) u_rise_detect (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .levelIn   (eventLevels),
        .risePulse (eventPulses)
    );

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    event_irq #(
        .WIDTH (EVT_WIDTH)
    ) u_event_irq (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .eventPulse  (eventPulses),
        .clearStatus (eventStatusRead),
        .maskIn      (eventMask_reg),
        .eventStatus (eventStatus),
        .irq         (eventIrq)
    );

endmodule

/* File: rtl/event_irq.v */
`timescale 1ns/1ns

module event_irq #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             reset_n,
    // Events and software control
    input  wire [WIDTH-1:0] eventPulse,
    input  wire             clearStatus,
    input  wire [WIDTH-1:0] maskIn,
    // Results
    output reg  [WIDTH-1:0] eventStatus,
    output reg              irq
);

    reg [WIDTH-1:0] statusNext;

    // ************************************************************
    // Sticky status, set wins over read clear
    // ************************************************************
    always @* begin
        statusNext = clearStatus ? eventPulse : (eventStatus | eventPulse);
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            eventStatus <= {WIDTH{1'b0}};
            irq         <= 1'b0;
        end else begin
            eventStatus <= statusNext;
            irq         <= |(statusNext & maskIn);
        end
    end

endmodule

/* File: rtl/rise_detect.v */
`timescale 1ns/1ns

module rise_detect #(
    parameter             WIDTH       = 4,
    parameter [WIDTH-1:0] RESET_LEVEL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             reset_n,
    // Levels and pulses
    input  wire [WIDTH-1:0] levelIn,
    output reg  [WIDTH-1:0] risePulse
);

    reg [WIDTH-1:0] levelDly_reg;

    // ************************************************************
    // Edge detection
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gen_rise
            always @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    levelDly_reg[i] <= RESET_LEVEL[i];
                    risePulse[i]    <= 1'b0;
                end else begin
                    levelDly_reg[i] <= levelIn[i];
                    risePulse[i]    <= levelIn[i] & ~levelDly_reg[i];
                end
            end
        end
    endgenerate

endmodule

/* File: verification/crc_fifo_timer_status_monitor.sv */
`timescale 1ns/1ns
`include "crc_fifo_timer_status_consts.vh"

module crc_fifo_timer_status_monitor #(
    parameter IRQ_SRC_WIDTH = 11
) (
    // Clock and reset
    input wire                     core_clk,
    input wire                     reset_n,
    // Wishbone
    input wire                     wbCyc,
    input wire                     wbStb,
    input wire                     wbWe,
    input wire [7:0]               wbAdr,
    input wire [3:0]               wbSel,
    input wire [31:0]              wbDatIn,
    input wire [31:0]              wbDatOut,
    input wire                     wbAck,
    // Unit state
    input wire                     crcBusy,
    input wire                     crcResultZero,
    input wire                     crcDone,
    input wire                     timerRunning,
    input wire                     timerEnabled,
    input wire                     timerGatedMode,
    input wire [6:0]               fifoFillCount,
    input wire [IRQ_SRC_WIDTH-1:0] irqPending,
    input wire [IRQ_SRC_WIDTH-1:0] irqEnable,
    // Results
    input wire [7:0]               statusFlags,
    input wire                     fifoNearEmptyLatch,
    input wire                     irq
);
    // ****************************************
    // Threshold shadow and warm-up flag
    // ****************************************
    reg       upReg;
    reg [5:0] thrReg;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            upReg  <= 1'b0;
            thrReg <= `RST_FIFO_THRESHOLD;
        end else begin
            upReg <= 1'b1;
            if (wbCyc && wbStb && !wbAck && wbWe && wbSel[0] && wbAdr[7:2] == `IDX_FIFO_THRESHOLD)
                thrReg <= wbDatIn[5:0];
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ****************************************
    // Assertions
    // ****************************************
    a_ack_follows_take: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("request not acknowledged next cycle");
    a_ack_single_pulse: assert property (wbAck |=> !wbAck)
        else $error("ack longer than one cycle");
    a_data_idle_zero: assert property (!wbAck |-> wbDatOut == 32'h0)
        else $error("read data outside ack");
    a_status_read: assert property (wbAck && !wbWe && wbAdr[7:2] == `IDX_CRC_FIFO_TIMER_STATUS
        |-> wbDatOut == {24'h0, $past(statusFlags)}) else $error("status read mismatch");
    a_crc_flags: assert property (upReg |-> statusFlags[6:5] ==
        $past({crcResultZero & !crcBusy, crcDone & !crcBusy})) else $error("crc flags wrong");
    a_attention_bit: assert property (upReg |-> statusFlags[4] == $past(|(irqPending & irqEnable)))
        else $error("attention bit wrong");
    a_timer_active: assert property (upReg |-> statusFlags[3] ==
        $past(timerGatedMode ? timerEnabled : timerRunning)) else $error("timer bit wrong");
    a_near_full: assert property (upReg |-> statusFlags[1] ==
        ((8'h40 - {1'b0, $past(fifoFillCount)}) <= {2'h0, $past(thrReg)})) else $error("near-full wrong");
    a_near_empty: assert property (upReg |-> statusFlags[0] ==
        ($past(fifoFillCount) <= {1'b0, $past(thrReg)})) else $error("near-empty wrong");
    a_reserved_zero: assert property (statusFlags[7] == 1'b0 && statusFlags[2] == 1'b0)
        else $error("reserved bit set");
    a_latch_on_rise: assert property (upReg && $rose(statusFlags[0]) |-> ##[1:2] fifoNearEmptyLatch)
        else $error("latch not set on near-empty rise");

    cover property (wbAck && !wbWe && wbAdr[7:2] == `IDX_CRC_FIFO_TIMER_STATUS);
    cover property ($rose(fifoNearEmptyLatch));
    cover property ($rose(irq));
endmodule

bind crc_fifo_timer_status_register crc_fifo_timer_status_monitor #(.IRQ_SRC_WIDTH(IRQ_SRC_WIDTH)) monitorInst (
    .core_clk(core_clk), .reset_n(reset_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .crcBusy(crcBusy),
    .crcResultZero(crcResultZero), .crcDone(crcDone), .timerRunning(timerRunning), .timerEnabled(timerEnabled),
    .timerGatedMode(timerGatedMode), .fifoFillCount(fifoFillCount), .irqPending(irqPending),
    .irqEnable(irqEnable), .statusFlags(statusFlags), .fifoNearEmptyLatch(fifoNearEmptyLatch), .irq(irq));

/* File: verification/crc_fifo_timer_status_register_tb_top.sv */
`timescale 1ns/1ns
`include "crc_fifo_timer_status_consts.vh"

module crc_fifo_timer_status_register_tb_top;
    localparam [103:0] FIFO_TBL = {6'h04, 7'h04, 6'h04, 7'h05, 6'h04, 7'h3b, 6'h04, 7'h3c,
                                   6'h00, 7'h00, 6'h00, 7'h40, 6'h3f, 7'h01, 6'h3f, 7'h00};
    reg         core_clk, reset_n, wbCyc, wbStb, wbWe;
    reg         crcBusy, crcResultZero, crcDone, timerRunning, timerEnabled, timerGatedMode;
    reg  [7:0]  wbAdr;
    reg  [3:0]  wbSel;
    reg  [31:0] wbDatIn, rd;
    reg  [6:0]  fifoFillCount, fill;
    reg  [10:0] irqPending, irqEnable;
    reg  [5:0]  thr;
    wire [31:0] wbDatOut;
    wire [7:0]  statusFlags;
    wire        wbAck, fifoNearEmptyLatch, irq;
    integer     miscompares, testsRun, i;

    crc_fifo_timer_status_register #(.IRQ_SRC_WIDTH(11)) DUT (
        .core_clk(core_clk), .reset_n(reset_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .crcBusy(crcBusy),
        .crcResultZero(crcResultZero), .crcDone(crcDone), .timerRunning(timerRunning),
        .timerEnabled(timerEnabled), .timerGatedMode(timerGatedMode), .fifoFillCount(fifoFillCount),
        .irqPending(irqPending), .irqEnable(irqEnable), .statusFlags(statusFlags),
        .fifoNearEmptyLatch(fifoNearEmptyLatch), .irq(irq));

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    // ****************************************
    // Tasks
    // ****************************************
    task check(input [31:0] seen, input [31:0] exp);
        begin
            testsRun = testsRun + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task xfer(input [5:0] idx, input we, input [3:0] sel, input [31:0] d);
        integer n;
        begin
            @(posedge core_clk);
            wbCyc <= 1'b1;
            wbStb <= 1'b1;
            wbWe <= we;
            wbAdr <= {idx, 2'b00};
            wbSel <= sel;
            wbDatIn <= d;
            n = 0;
            @(posedge core_clk);
            while (wbAck !== 1'b1 && n < 20) begin
                @(posedge core_clk);
                n = n + 1;
            end
            if (n == 20) begin
                miscompares = miscompares + 1;
                complete_run;
            end
            rd = wbDatOut;
            wbCyc <= 1'b0;
            wbStb <= 1'b0;
            wbWe <= 1'b0;
        end
    endtask

    task setIn(input [2:0] crc, input [2:0] tmr, input [6:0] f);
        begin
            @(posedge core_clk);
            {crcBusy, crcResultZero, crcDone} <= crc;
            {timerGatedMode, timerEnabled, timerRunning} <= tmr;
            fifoFillCount <= f;
        end
    endtask

    task stChk;
        begin
            xfer(`IDX_CRC_FIFO_TIMER_STATUS, 1'b0, 4'hf, 32'h0);
            check(rd, {24'h0, 1'b0, crcResultZero & !crcBusy, crcDone & !crcBusy, |(irqPending & irqEnable),
                  timerGatedMode ? timerEnabled : timerRunning, 1'b0,
                  (8'h40 - {1'b0, fifoFillCount}) <= {2'h0, thr}, fifoFillCount <= {1'b0, thr}});
        end
    endtask

    task complete_run;
        begin
            $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
            if (miscompares == 0 && testsRun > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares = miscompares + 1;
        complete_run;
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        miscompares = 0;
        testsRun = 0;
        {reset_n, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatIn} = 0;
        {crcBusy, crcResultZero, crcDone, timerRunning, timerEnabled, timerGatedMode} = 6'h08;
        {fifoFillCount, irqPending, irqEnable} = 0;
        thr = 6'h08;
        repeat (10) @(posedge core_clk);
        check({24'h0, statusFlags}, 32'h21);
        reset_n <= 1'b1;
        xfer(`IDX_CRC_FIFO_TIMER_STATUS, 1'b0, 4'hf, 32'h0);
        check(rd, 32'h21);
        xfer(`IDX_FIFO_THRESHOLD, 1'b1, 4'he, 32'h3);
        xfer(`IDX_FIFO_THRESHOLD, 1'b0, 4'hf, 32'h0);
        check(rd, 32'h08);
        xfer(`IDX_CRC_FIFO_TIMER_STATUS, 1'b1, 4'hf, 32'hffffffff);
        stChk();
        xfer(6'h3f, 1'b1, 4'hf, 32'hffffffff);
        xfer(6'h3f, 1'b0, 4'hf, 32'h0);
        check(rd, 32'h0);
        $display("Test reset and access done");
        for (i = 0; i < 8; i = i + 1) begin
            setIn(i[2:0], 3'h0, 7'h0a);
            stChk();
            setIn(3'h0, i[2:0], 7'h0a);
            stChk();
        end
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge core_clk);
            irqPending <= 11'h404 & {11{i[0]}};
            irqEnable <= i[1] ? 11'h400 : 11'h004;
            stChk();
        end
        $display("Test crc timer attention done");
        for (i = 0; i < 8; i = i + 1) begin
            {thr, fill} = FIFO_TBL[i*13 +: 13];
            xfer(`IDX_FIFO_THRESHOLD, 1'b1, 4'h1, {26'h0, thr});
            setIn(3'h0, 3'h0, fill);
            stChk();
        end
        $display("Test fifo alerts done");
        thr = 6'h04;
        xfer(`IDX_FIFO_THRESHOLD, 1'b1, 4'h1, 32'h4);
        setIn(3'h0, 3'h0, 7'h0a);
        xfer(`IDX_NEAR_EMPTY_LATCH, 1'b1, 4'h1, 32'h04);
        check({31'h0, fifoNearEmptyLatch}, 32'h0);
        setIn(3'h0, 3'h0, 7'h02);
        repeat (3) @(posedge core_clk);
        xfer(`IDX_NEAR_EMPTY_LATCH, 1'b1, 4'h1, 32'h00);
        xfer(`IDX_NEAR_EMPTY_LATCH, 1'b0, 4'hf, 32'h0);
        check(rd & 32'h4, 32'h4);
        xfer(`IDX_NEAR_EMPTY_LATCH, 1'b1, 4'h1, 32'h04);
        check({31'h0, fifoNearEmptyLatch}, 32'h0);
        xfer(`IDX_NEAR_EMPTY_LATCH, 1'b1, 4'h1, 32'h84);
        check({31'h0, fifoNearEmptyLatch}, 32'h1);
        $display("Test near-empty latch done");
        xfer(`IDX_EVENT_MASK, 1'b1, 4'h1, 32'h1);
        for (i = 0; i < 2; i = i + 1) begin
            setIn(3'h0, 3'h0, 7'h02);
            repeat (5) @(posedge core_clk);
            xfer(`IDX_EVENT_STATUS, 1'b0, 4'hf, 32'h0);
            repeat (3) @(posedge core_clk);
            check({31'h0, irq}, 32'h0);
            setIn(3'h1, 3'h0, 7'h02);
            repeat (5) @(posedge core_clk);
            check({31'h0, irq}, {31'h0, ~i[0]});
            xfer(`IDX_EVENT_STATUS, 1'b0, 4'hf, 32'h0);
            check(rd, 32'h1);
            repeat (3) @(posedge core_clk);
            check({31'h0, irq}, 32'h0);
            xfer(`IDX_EVENT_MASK, 1'b1, 4'h1, 32'h0);
        end
        $display("Test interrupt done");
        complete_run;
    end
endmodule
